// File: logic/mac_pause_flow_control.sv
`timescale 1ns/100ps
module mac_pause_flow_control import flow_ctrl_pkg::*; #(
    parameter int REPEAT_CYCLES = REPEAT_CYC
) (
    // Clock and reset
    input  logic        core_clk,
    input  logic        rst_n,
    // Byte register port
    input  logic [2:0]  reg_addr,
    input  logic        reg_wr,
    input  logic        reg_rd,
    input  logic [7:0]  reg_wdata,
    output logic [7:0]  reg_rdata,
    // MAC configuration
    input  logic        mac_full_duplex,
    input  logic [47:0] station_addr,
    // Host packet stream
    input  logic        host_valid,
    input  tx_beat_s    host_beat,
    output logic        host_ready,
    // Transmit stream to the medium
    output logic        tx_valid,
    output tx_beat_s    tx_beat,
    input  logic        tx_ready,
    input  logic        tx_abort,
    output logic        tx_jam,
    // Receive side
    input  rx_pause_s   rx_pause,
    input  logic        rx_ctrl_frame,
    output logic        rx_ctrl_deliver,
    output logic        mac_paused
);

    default clocking prop_clk @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    localparam int QW = $clog2(QUANTA_CYC);
    localparam logic [QW-1:0] QUANTA_LAST = QW'(QUANTA_CYC - 1);

    logic [7:0]      ectl_q;
    logic [7:0]      mctl_q;
    logic [7:0]      gap_q;
    logic [1:0]      mode_q;
    logic [15:0]     pause_time_q;
    logic [7:0]      reg_rdata_q;
    logic [15:0]     timer_q;
    logic [QW-1:0]   quanta_q;
    logic [15:0]     rep_cnt_q;
    logic [6:0]      gap_cnt_q;
    tx_state_e       state_q;
    tx_state_e       state_d;

    logic            txreq_q;
    logic            pause_tx_enable;
    logic            pause_rx_honor;
    logic            pass_all_frames;
    logic            flow_wr;
    logic            half_on;
    logic            pf_pending;
    logic            pf_start;
    logic [15:0]     pf_time;
    logic            pf_valid;
    tx_beat_s        pf_beat;
    logic            pf_ready;
    logic            tx_done;

    assign txreq_q         = ectl_q[ECTL_TXREQ_BIT];
    assign pause_tx_enable = mctl_q[MCTL_TXPAUSE_BIT];
    assign pause_rx_honor  = mctl_q[MCTL_RXPAUSE_BIT];
    assign pass_all_frames = mctl_q[MCTL_PASS_ALL_FRAMES_BIT];
    assign flow_wr         = reg_wr && (reg_addr == REG_FLOW);

    // Registers written by the host.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ectl_q <= REG_RST;
        end else if (reg_wr && reg_addr == REG_ETH_CTRL1) begin
            ectl_q <= reg_wdata;
        end else if (tx_done) begin
            ectl_q[ECTL_TXREQ_BIT] <= 1'b0; // R07
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mctl_q       <= REG_RST;
            gap_q        <= REG_RST;
            pause_time_q <= PAUSE_TIME_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                REG_MAC_CTRL1: mctl_q <= reg_wdata & MAC_CTRL1_MASK;
                REG_BB_GAP:    gap_q <= reg_wdata & BB_GAP_MASK;
                REG_PAUSE_LO:  pause_time_q[7:0] <= reg_wdata; // R12
                REG_PAUSE_HI:  pause_time_q[15:8] <= reg_wdata; // R12
                default:       ;
            endcase
        end
    end

    // A host write wins over the hardware turning a one-shot mode off, so a
    // fresh command issued as the frame starts is never discarded.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            mode_q <= MODE_OFF;
        end else if (flow_wr) begin
            mode_q <= reg_wdata[1:0]; // R02 R05
        end else if (pf_start && (mode_q == MODE_ONCE ||
                                  mode_q == MODE_STOP)) begin
            mode_q <= MODE_OFF; // R10
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata_q <= REG_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_ETH_CTRL1: reg_rdata_q <= ectl_q;
                REG_MAC_CTRL1: reg_rdata_q <= mctl_q;
                REG_BB_GAP:    reg_rdata_q <= gap_q;
                REG_FLOW:      reg_rdata_q <= {5'b00000, mac_full_duplex,
                                               mode_q}; // R09
                REG_PAUSE_LO:  reg_rdata_q <= pause_time_q[7:0];
                REG_PAUSE_HI:  reg_rdata_q <= pause_time_q[15:8];
                default:       reg_rdata_q <= REG_RST;
            endcase
        end
    end

    assign reg_rdata = reg_rdata_q;

    // Pause timer set by frames from the remote node.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            timer_q  <= 16'h0000;
            quanta_q <= '0;
        end else if (rx_pause.valid && pause_rx_honor) begin
            timer_q  <= rx_pause.timer; // R06 R15
            quanta_q <= '0;
        end else if (timer_q != 16'h0000) begin
            if (quanta_q == QUANTA_LAST) begin
                timer_q  <= timer_q - 16'h0001; // R14
                quanta_q <= '0;
            end else begin
                quanta_q <= quanta_q + QW'(1);
            end
        end
    end

    assign mac_paused      = (timer_q != 16'h0000);
    assign rx_ctrl_deliver = rx_ctrl_frame && pass_all_frames; // R08

    // Pause frames need the transmit enable; the receive enable gates the
    // timer above, so both must be set for full-duplex flow control.
    assign half_on    = !mac_full_duplex && mode_q[0]; // R11
    assign pf_pending = mac_full_duplex && pause_tx_enable && // R01
                        (mode_q == MODE_ONCE || mode_q == MODE_STOP ||
                         (mode_q == MODE_PERIODIC &&
                          rep_cnt_q == 16'h0000)); // R10
    assign pf_time    = (mode_q == MODE_STOP) ? 16'h0000 // R05
                                              : pause_time_q; // R03

    // The repeat spacing, counted from each frame start, leaves idle slots in which a waiting host
    // packet is taken only when REPEAT_CYCLES outlasts the frame, so only then can periodic frames not starve host traffic.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rep_cnt_q <= 16'h0000;
        end else if (flow_wr) begin
            rep_cnt_q <= 16'h0000;
        end else if (pf_start && mode_q == MODE_PERIODIC) begin
            rep_cnt_q <= 16'(REPEAT_CYCLES); // R03 R04
        end else if (rep_cnt_q != 16'h0000) begin
            rep_cnt_q <= rep_cnt_q - 16'h0001;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (pf_pending) begin
                    state_d = ST_PAUSE_TX;
                end else if (txreq_q && !(mac_full_duplex && mac_paused)) begin
                    state_d = ST_HOST_GAP; // R04 R07
                end else if (half_on) begin
                    state_d = ST_JAM; // R16
                end
            end
            ST_PAUSE_TX: begin
                if (pf_valid && tx_ready && pf_beat.last) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HOST_GAP: begin
                if (gap_cnt_q >= gap_q[6:0]) begin
                    state_d = ST_HOST_TX; // R16
                end
            end
            ST_HOST_TX: begin
                if (tx_done) begin
                    state_d = ST_IDLE; // R16
                end
            end
            ST_JAM: begin
                if (txreq_q || !half_on) begin
                    state_d = ST_IDLE; // R16
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            gap_cnt_q <= 7'h00;
        end else if (state_q == ST_HOST_GAP) begin
            gap_cnt_q <= gap_cnt_q + 7'h01;
        end else begin
            gap_cnt_q <= 7'h00;
        end
    end

    assign pf_start = (state_q == ST_IDLE) && (state_d == ST_PAUSE_TX);
    assign tx_done  = (state_q == ST_HOST_TX) &&
                      (tx_abort || (host_valid && tx_ready && host_beat.last));

    pause_frame_gen u_gen (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .start      (pf_start),
        .timer      (pf_time),
        .src_addr   (station_addr),
        .beat_valid (pf_valid),
        .beat       (pf_beat),
        .beat_ready (pf_ready)
    );

    always_comb begin
        tx_valid = 1'b0;
        tx_beat  = '0;
        case (state_q)
            ST_PAUSE_TX: begin
                tx_valid = pf_valid;
                tx_beat  = pf_beat;
            end
            ST_HOST_TX: begin
                tx_valid = host_valid;
                tx_beat  = host_beat;
            end
            ST_JAM: begin
                tx_valid     = 1'b1;
                tx_beat.data = JAM_BYTE; // R16
            end
            default: ;
        endcase
    end

    assign pf_ready   = (state_q == ST_PAUSE_TX) && tx_ready;
    assign host_ready = (state_q == ST_HOST_TX) && tx_ready;
    assign tx_jam     = (state_q == ST_JAM);

    property p_rx_pause;
        (rx_pause.valid && pause_rx_honor && rx_pause.timer != 16'h0000)
        |=> mac_paused;
    endproperty
    a_rx_pause: assert property (p_rx_pause) // R06
        else $error("non-zero pause frame did not pause transmit");
    property p_rx_zero;
        (rx_pause.valid && pause_rx_honor && rx_pause.timer == 16'h0000)
        |=> !mac_paused;
    endproperty
    a_rx_zero: assert property (p_rx_zero) // R15
        else $error("zero pause frame did not resume transmit");
    property p_quanta;
        (mac_paused && quanta_q == QUANTA_LAST && !rx_pause.valid)
        |=> timer_q == $past(timer_q) - 16'h0001;
    endproperty
    a_quanta: assert property (p_quanta) // R14
        else $error("pause timer missed its quanta decrement");
    property p_paused_hold;
        (mac_full_duplex && mac_paused && state_q == ST_IDLE)
        |=> state_q != ST_HOST_GAP;
    endproperty
    a_paused_hold: assert property (p_paused_hold) // R07
        else $error("host packet started while paused");
    property p_req_clear;
        (state_q == ST_HOST_TX && tx_abort && !reg_wr)
        |=> !txreq_q && state_q == ST_IDLE;
    endproperty
    a_req_clear: assert property (p_req_clear) // R07
        else $error("transmit request not cleared at packet end");
    property p_fdx_mirror;
        (reg_rd && reg_addr == REG_FLOW)
        |=> reg_rdata[FLOW_FDX_BIT] == $past(mac_full_duplex)
            && reg_rdata[7:3] == 5'b00000;
    endproperty
    a_fdx_mirror: assert property (p_fdx_mirror) // R09
        else $error("flow control read does not mirror duplex");
    property p_once_off;
        (pf_start && mode_q == MODE_ONCE && !flow_wr) |=> mode_q == MODE_OFF;
    endproperty
    a_once_off: assert property (p_once_off) // R10
        else $error("one-shot mode did not turn off");
    property p_stop_zero;
        (pf_start && mode_q == MODE_STOP && !flow_wr)
        |-> pf_time == 16'h0000 ##1 mode_q == MODE_OFF;
    endproperty
    a_stop_zero: assert property (p_stop_zero) // R05
        else $error("final pause frame not zero or mode not off");
    property p_periodic;
        (pf_start && mode_q == MODE_PERIODIC && !flow_wr)
        |-> pf_time == pause_time_q ##1 mode_q == MODE_PERIODIC;
    endproperty
    a_periodic: assert property (p_periodic) // R03
        else $error("periodic pause frame time or mode wrong");
    // The jam state leaves one cycle after the mode changes, so the mode
    // that put or kept it there is the one of the cycle before.
    property p_jam_mode;
        tx_jam |-> $past(!mac_full_duplex && mode_q[0]);
    endproperty
    a_jam_mode: assert property (p_jam_mode) // R11
        else $error("jamming while half-duplex flow control off");
    property p_jam_start;
        (half_on && state_q == ST_IDLE && !txreq_q)
        |=> tx_valid && tx_beat.data == JAM_BYTE;
    endproperty
    a_jam_start: assert property (p_jam_start) // R16
        else $error("jam pattern did not start");
    property p_pause_hi;
        (reg_wr && reg_addr == REG_PAUSE_HI)
        |=> pause_time_q[15:8] == $past(reg_wdata);
    endproperty
    a_pause_hi: assert property (p_pause_hi) // R12
        else $error("pause time high byte not stored");

endmodule

// File: pkg/flow_ctrl_pkg.sv
// Operation
// R01 - Host sets pause transmit and receive enables for full-duplex control.
// R02 - Host starts flow control by writing 02h when receive space runs low.
// R03 - Periodic mode repeatedly sends pause frames with the programmed time.
// R04 - Host packets still go out between pause frames, neither disturbed.
// R05 - Writing 03h ends flow control with one final pause frame of 0000h.
// R06 - A received non-zero pause frame blocks own transmits when honoured.
// R07 - Requests while paused wait for timer expiry, then send and clear.
// R08 - Control frames are dropped silently unless pass-all-frames is set.
// R09 - Flow control bit 2 mirrors the MAC full-duplex bit, read only.
// R10 - Full duplex: 11 zero frame, off; 10 periodic; 01 one frame, off.
// R11 - Half duplex: codes 11 and 01 turn flow control on, 10 and 00 off.
// R12 - The 16-bit pause time lives in a low and a high byte register.
// R13 - A 64-byte pause frame: multicast, source, opcode, timer, pad, CRC.
// R14 - The pause timer counts down once per 512 bit times, 51.2 us.
// R15 - A new frame reloads the timer; a zero timer or frame resumes sending.
// R16 - Half duplex jams 55h, yielding to a requested packet after the gap.
package flow_ctrl_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int QUANTA_NS     = 51200;
    localparam int QUANTA_CYC    = QUANTA_NS / CLK_PERIOD_NS;
    localparam int REPEAT_CYC    = 1024;

    localparam logic [2:0] REG_ETH_CTRL1  = 3'h0;
    localparam logic [2:0] REG_MAC_CTRL1  = 3'h1;
    localparam logic [2:0] REG_BB_GAP     = 3'h2;
    localparam logic [2:0] REG_FLOW       = 3'h3;
    localparam logic [2:0] REG_PAUSE_LO   = 3'h4;
    localparam logic [2:0] REG_PAUSE_HI   = 3'h5;

    localparam int ECTL_TXREQ_BIT   = 3;
    localparam int MCTL_TXPAUSE_BIT = 3;
    localparam int MCTL_RXPAUSE_BIT = 2;
    localparam int MCTL_PASS_ALL_FRAMES_BIT = 1;
    localparam int FLOW_FDX_BIT     = 2;

    localparam logic [7:0]  MAC_CTRL1_MASK = 8'h0F;
    localparam logic [7:0]  BB_GAP_MASK    = 8'h7F;
    localparam logic [7:0]  REG_RST        = 8'h00;
    localparam logic [15:0] PAUSE_TIME_RST = 16'h0000;

    localparam logic [1:0] MODE_OFF      = 2'b00;
    localparam logic [1:0] MODE_ONCE     = 2'b01;
    localparam logic [1:0] MODE_PERIODIC = 2'b10;
    localparam logic [1:0] MODE_STOP     = 2'b11;

    localparam logic [7:0]  JAM_BYTE     = 8'h55;
    localparam logic [47:0] PAUSE_DA     = 48'h0180C2000001;
    localparam logic [15:0] CTRL_TYPE    = 16'h8808;
    localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
    localparam logic [5:0]  FRAME_LAST   = 6'h3F;
    localparam logic [5:0]  CRC_FIRST    = 6'h3C;
    localparam logic [31:0] CRC_POLY     = 32'hEDB88320;
    localparam logic [31:0] CRC_INIT     = 32'hFFFFFFFF;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } tx_beat_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] timer;
    } rx_pause_s;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_PAUSE_TX,
        ST_HOST_GAP,
        ST_HOST_TX,
        ST_JAM
    } tx_state_e;

endpackage

// File: logic/pause_frame_gen.sv
`timescale 1ns/100ps
module pause_frame_gen import flow_ctrl_pkg::*; (
    // Clock and reset
    input  logic        core_clk,
    input  logic        rst_n,
    // Frame request
    input  logic        start,
    input  logic [15:0] timer,
    input  logic [47:0] src_addr,
    // Byte stream out
    output logic        beat_valid,
    output tx_beat_s    beat,
    input  logic        beat_ready
);

    logic [5:0]  idx_q;
    logic        busy_q;
    logic [31:0] crc_q;
    logic [15:0] timer_q;
    logic [47:0] sa_q;
    logic [31:0] crc_fin;
    logic [7:0]  byte_d;

    function automatic logic [31:0] crc_next(input logic [31:0] c,
                                             input logic [7:0]  d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    assign crc_fin = ~crc_q;

    // Frame layout, one byte per index.
    always_comb begin
        byte_d = 8'h00;
        if (idx_q < 6'd6) begin
            byte_d = PAUSE_DA[8'(47 - 8 * idx_q) -: 8]; // R13
        end else if (idx_q < 6'd12) begin
            byte_d = sa_q[8'(47 - 8 * (idx_q - 6'd6)) -: 8];
        end else if (idx_q == 6'd12) begin
            byte_d = CTRL_TYPE[15:8];
        end else if (idx_q == 6'd13) begin
            byte_d = CTRL_TYPE[7:0];
        end else if (idx_q == 6'd14) begin
            byte_d = PAUSE_OPCODE[15:8];
        end else if (idx_q == 6'd15) begin
            byte_d = PAUSE_OPCODE[7:0];
        end else if (idx_q == 6'd16) begin
            byte_d = timer_q[15:8];
        end else if (idx_q == 6'd17) begin
            byte_d = timer_q[7:0];
        end else if (idx_q >= CRC_FIRST) begin
            byte_d = crc_fin[{idx_q[1:0], 3'b000} +: 8]; // R13
        end
    end

    assign beat_valid = busy_q;
    assign beat.data  = byte_d;
    assign beat.last  = (idx_q == FRAME_LAST);

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_q  <= 1'b0;
            idx_q   <= 6'h00;
            crc_q   <= CRC_INIT;
            timer_q <= PAUSE_TIME_RST;
            sa_q    <= 48'h000000000000;
        end else if (!busy_q && start) begin
            busy_q  <= 1'b1;
            idx_q   <= 6'h00;
            crc_q   <= CRC_INIT;
            timer_q <= timer;
            sa_q    <= src_addr;
        end else if (busy_q && beat_ready) begin
            idx_q <= idx_q + 6'h01;
            if (idx_q < CRC_FIRST) begin
                crc_q <= crc_next(crc_q, byte_d);
            end
            if (idx_q == FRAME_LAST) begin
                busy_q <= 1'b0;
            end
        end
    end

    property p_frame_len;
        @(posedge core_clk) disable iff (!rst_n)
        (beat_valid && beat_ready && beat.last) |=> !beat_valid;
    endproperty
    a_frame_len: assert property (p_frame_len) // R13
        else $error("pause frame did not end after its last byte");

    property p_frame_dest;
        @(posedge core_clk) disable iff (!rst_n)
        (!busy_q && start) |=> (beat_valid && beat.data == PAUSE_DA[47:40]
                                && !beat.last);
    endproperty
    a_frame_dest: assert property (p_frame_dest) // R13
        else $error("pause frame does not open with reserved address");

endmodule

// File: test/remote_node.sv
`timescale 1ns/100ps
module remote_node import flow_ctrl_pkg::*; (
    // Clock and reset
    input  logic      core_clk,
    input  logic      rst_n,
    // Medium side
    input  logic      tx_valid,
    input  tx_beat_s  tx_beat,
    input  logic      tx_jam,
    output logic      tx_ready,
    output rx_pause_s rx_pause
);
    logic [7:0] frm [64];
    int         idx;
    int         nfr;
    int         nhost;
    logic       slow;

    initial begin
        slow = 1'b0;
        rx_pause = '{valid: 1'b0, timer: 16'hFFFF};
    end

    // A slow node takes a byte every other cycle; jam bytes are not frames.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            tx_ready <= 1'b0;
            idx <= 0;
            nfr <= 0;
            nhost <= 0;
        end else begin
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready && !tx_jam) begin
                if (idx < 64) frm[idx] <= tx_beat.data;
                idx <= tx_beat.last ? 0 : idx + 1;
                if (tx_beat.last && idx == 63) nfr <= nfr + 1;
                if (tx_beat.last && idx == 0) nhost <= nhost + 1;
            end
        end
    end

    // The timer lines carry no stale value once the pulse has gone.
    task automatic send_pause(input logic [15:0] t);
        @(posedge core_clk);
        #1 rx_pause = '{valid: 1'b1, timer: t};
        @(posedge core_clk);
        #1 rx_pause = '{valid: 1'b0, timer: ~t};
    endtask
endmodule

// File: test/mac_pause_flow_control_test.sv
`timescale 1ns/100ps
module mac_pause_flow_control_test import flow_ctrl_pkg::*; ;
    localparam int          REP = 80;
    localparam logic [47:0] SA  = 48'h02AB_CD00_1122;
    logic        core_clk;
    logic        rst_n;
    logic [2:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_wdata;
    logic [7:0]  reg_rdata;
    logic        fdx;
    logic        host_valid;
    tx_beat_s    host_beat;
    logic        host_ready;
    logic        tx_valid;
    tx_beat_s    tx_beat;
    logic        tx_ready;
    logic        tx_abort;
    logic        tx_jam;
    rx_pause_s   rx_pause;
    logic        rx_ctrl_frame;
    logic        rx_ctrl_deliver;
    logic        mac_paused;
    int          error_cnt;
    int          check_count;

    mac_pause_flow_control #(.REPEAT_CYCLES(REP)) DUT (
        .core_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .reg_rdata, .mac_full_duplex(fdx), .station_addr(SA),
        .host_valid, .host_beat,
        .host_ready, .tx_valid, .tx_beat, .tx_ready, .tx_abort,
        .tx_jam, .rx_pause, .rx_ctrl_frame, .rx_ctrl_deliver, .mac_paused);

    remote_node p (.core_clk, .rst_n, .tx_valid, .tx_beat, .tx_jam,
        .tx_ready, .rx_pause);

    always #25 core_clk = ~core_clk;

    task automatic complete_run();
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: byte %h not %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: flag %b not %b", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        #1 reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge core_clk);
        #1 reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
        @(posedge core_clk);
        #1 reg_rd = 1'b1;
        reg_addr = a;
        @(posedge core_clk);
        #1 reg_rd = 1'b0;
        @(posedge core_clk);
        #1 chk_byte(reg_rdata, e);
    endtask

    task automatic wait_frames(input int n, input int lim);
        int k;
        k = 0;
        while (p.nfr < n && k < lim) begin
            @(posedge core_clk);
            #1 k++;
        end
    endtask

    task automatic chk_frame(input logic [15:0] t);
        logic [143:0] h;
        h = {PAUSE_DA, SA, CTRL_TYPE, PAUSE_OPCODE, t};
        for (int i = 0; i < 18; i++) chk_byte(p.frm[i], h[143-8*i -: 8]);
        for (int i = 18; i < 60; i++) chk_byte(p.frm[i], 8'h00);
    endtask

    task automatic t_regs();
        for (int a = 0; a < 8; a++) begin
            rd_chk(3'(a), (a == 3) ? 8'h04 : 8'h00);
        end
        wr(REG_MAC_CTRL1, 8'hFF);
        rd_chk(REG_MAC_CTRL1, 8'h0F);
        wr(REG_BB_GAP, 8'hFF);
        rd_chk(REG_BB_GAP, 8'h7F);
        wr(REG_FLOW, 8'hF8);
        rd_chk(REG_FLOW, 8'h04);
        fdx = 1'b0;
        rd_chk(REG_FLOW, 8'h00);
        fdx = 1'b1;
        wr(3'h6, 8'hFF);
        rd_chk(3'h6, 8'h00);
        wr(REG_MAC_CTRL1, 8'h00);
        wr(REG_BB_GAP, 8'h00);
    endtask

    task automatic t_once();
        p.slow = 1'b1;
        wr(REG_PAUSE_LO, 8'h34);
        wr(REG_PAUSE_HI, 8'h12);
        rd_chk(REG_PAUSE_LO, 8'h34);
        rd_chk(REG_PAUSE_HI, 8'h12);
        wr(REG_MAC_CTRL1, 8'h0C);
        wr(REG_FLOW, 8'h01);
        wait_frames(p.nfr + 1, 400);
        chk_frame(16'h1234);
        rd_chk(REG_FLOW, 8'h04);
        p.slow = 1'b0;
    endtask

    task automatic t_period();
        int h;
        int n;
        h = p.nhost;
        n = p.nfr;
        wr(REG_FLOW, 8'h02);
        wr(REG_ETH_CTRL1, 8'h08);
        wait_frames(n + 3, 4 * REP + 200);
        chk_bit(p.nhost == h + 1, 1'b1);
        chk_frame(16'h1234);
        wr(REG_FLOW, 8'h03);
        wait_frames(n + 4, 2 * REP + 100);
        chk_frame(16'h0000);
        n = p.nfr;
        repeat (2 * REP) @(posedge core_clk);
        chk_bit(p.nfr == n, 1'b1);
        rd_chk(REG_FLOW, 8'h04);
    endtask

    task automatic t_paused();
        int h;
        int k;
        wr(REG_BB_GAP, 8'h03);
        h = p.nhost;
        p.send_pause(16'h0001);
        chk_bit(mac_paused, 1'b1);
        wr(REG_ETH_CTRL1, 8'h08);
        repeat (600) @(posedge core_clk);
        #1 chk_bit(p.nhost == h, 1'b1);
        k = 600;
        while (mac_paused === 1'b1 && k < 1200) begin
            @(posedge core_clk);
            #1 k++;
        end
        chk_bit(k > 1015 && k < 1035, 1'b1);
        repeat (20) @(posedge core_clk);
        chk_bit(p.nhost == h + 1, 1'b1);
        rd_chk(REG_ETH_CTRL1, 8'h00);
        p.send_pause(16'h0100);
        chk_bit(mac_paused, 1'b1);
        p.send_pause(16'h0000);
        chk_bit(mac_paused, 1'b0);
    endtask

    task automatic t_ctrl();
        rx_ctrl_frame = 1'b1;
        wr(REG_MAC_CTRL1, 8'h08);
        chk_bit(rx_ctrl_deliver, 1'b0);
        p.send_pause(16'h0005);
        chk_bit(mac_paused, 1'b0);
        wr(REG_MAC_CTRL1, 8'h0A);
        chk_bit(rx_ctrl_deliver, 1'b1);
        rx_ctrl_frame = 1'b0;
    endtask

    task automatic t_half();
        logic [7:0] m [4] = '{8'h01, 8'h02, 8'h03, 8'h00};
        fdx = 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(REG_FLOW, m[i]);
            repeat (3) @(posedge core_clk);
            chk_bit(tx_jam, m[i][0]);
            chk_byte(tx_beat.data, m[i][0] ? JAM_BYTE : 8'h00);
            rd_chk(REG_FLOW, m[i]);
        end
        // A request stops the jam; an aborted packet lets it restart.
        host_valid = 1'b0;
        wr(REG_FLOW, 8'h01);
        wr(REG_ETH_CTRL1, 8'h08);
        repeat (8) @(posedge core_clk);
        #1 chk_bit(tx_jam, 1'b0);
        chk_bit(host_ready, 1'b1);
        chk_bit(tx_valid, 1'b0);
        tx_abort = 1'b1;
        @(posedge core_clk);
        #1 tx_abort = 1'b0;
        repeat (2) @(posedge core_clk);
        #1 chk_bit(tx_jam, 1'b1);
        chk_byte(tx_beat.data, JAM_BYTE);
        rd_chk(REG_ETH_CTRL1, 8'h00);
    endtask

    initial begin
        core_clk = 1'b0;
        rst_n = 1'b0;
        reg_addr = 3'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        fdx = 1'b1;
        rx_ctrl_frame = 1'b0;
        host_valid = 1'b1;
        host_beat = '{data: 8'hA5, last: 1'b1};
        tx_abort = 1'b0;
        error_cnt = 0;
        check_count = 0;
        repeat (20) @(posedge core_clk);
        #1 rst_n = 1'b1;
        t_regs();
        t_once();
        t_period();
        t_paused();
        t_ctrl();
        t_half();
        complete_run();
    end

    // The full sequence needs under two thousand cycles; this leaves ample room.
    initial begin
        #(50 * 12000);
        error_cnt++;
        complete_run();
    end
endmodule
